// *** shared/rcl_pkg.sv ***
// Package of register map, field positions and types for the control block.
package rcl_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_TIME     = 5'h00;
  localparam logic [4:0] OFF_DATE     = 5'h04;
  localparam logic [4:0] OFF_CONTROL  = 5'h08;
  localparam logic [4:0] OFF_STATUS   = 5'h0C;
  localparam logic [4:0] OFF_MASK     = 5'h10;
  localparam logic [4:0] OFF_RELOAD   = 5'h14;
  localparam logic [4:0] OFF_SYNC_DIV = 5'h18;
  localparam logic [4:0] OFF_STAMP    = 5'h1C;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int unsigned CTL_WAKEUP_IRQ  = 14;
  localparam int unsigned CTL_ALARM2_IRQ  = 13;
  localparam int unsigned CTL_ALARM1_IRQ  = 12;
  localparam int unsigned CTL_STAMP_EN    = 11;
  localparam int unsigned CTL_WAKEUP_ON   = 10;
  localparam int unsigned CTL_ALARM2_ON   = 9;
  localparam int unsigned CTL_ALARM1_ON   = 8;
  localparam int unsigned CTL_HOUR_FMT    = 6;
  localparam int unsigned CTL_BYPASS      = 5;
  localparam int unsigned CTL_REF_DETECT  = 4;
  localparam int unsigned CTL_STAMP_EDGE  = 3;
  localparam logic [31:0] CTL_WRITABLE    = 32'h0000_7F7F;
  localparam logic [31:0] CTL_RESET       = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Event status and mask fields
  // ----------------------------------------------------------------
  localparam int unsigned EVT_WAKEUP  = 0;
  localparam int unsigned EVT_ALARM1  = 1;
  localparam int unsigned EVT_ALARM2  = 2;
  localparam int unsigned EVT_STAMP   = 3;
  localparam int unsigned EVT_REF     = 4;
  localparam int unsigned EVT_COUNT   = 5;
  localparam logic [4:0]  EVT_RESET   = 5'h00;

  // ----------------------------------------------------------------
  // Other reset values and widths
  // ----------------------------------------------------------------
  localparam logic [15:0] RELOAD_RESET   = 16'hFFFF;
  localparam logic [14:0] SYNC_DIV_RESET = 15'h00FF;
  localparam int unsigned TIME_W         = 23;
  localparam int unsigned DATE_W         = 24;
  localparam int unsigned WK_CNT_W       = 17;

  // ----------------------------------------------------------------
  // Wakeup clock select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] WKSEL_DIV16 = 3'h0;
  localparam logic [2:0] WKSEL_DIV8  = 3'h1;
  localparam logic [2:0] WKSEL_DIV4  = 3'h2;
  localparam logic [2:0] WKSEL_DIV2  = 3'h3;

  typedef struct packed {
    logic [16:0] upper;
    logic        wakeup_irq_enable;
    logic        alarm2_irq_enable;
    logic        alarm1_irq_enable;
    logic        stamp_capture_enable;
    logic        wakeup_timer_on;
    logic        alarm2_on;
    logic        alarm1_on;
    logic        reserved7;
    logic        hour_format_select;
    logic        shadow_bypass;
    logic        mains_ref_detect_enable;
    logic        stamp_edge_select;
    logic [2:0]  wakeup_clock_select;
  } rcl_ctrl_t;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } rcl_bus_state_t;

endpackage

// *** logic/rcl_edge_sync.sv ***
// Two-stage pin synchroniser with rise and fall pulses.
`timescale 1ns/1ps
module rcl_edge_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Pin and results
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~last_q;
  assign fall  = ~sync_q & last_q;

endmodule

// *** logic/rcl_control.sv ***
// Control register, wakeup timer, shadow calendar, event flags and bus slave.
`timescale 1ns/1ps

module rcl_control (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset,
  // Avalon-MM slave
  input  wire logic [4:0]                    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [31:0]                   avs_readdata,
  output logic                               avs_waitrequest,
  // Pins
  input  wire logic                          calendar_clock,
  input  wire logic                          mains_ref_input,
  input  wire logic                          stamp_input,
  // Calendar core
  input  wire logic [rcl_pkg::TIME_W-1:0]    live_time,
  input  wire logic [rcl_pkg::DATE_W-1:0]    live_date,
  input  wire logic                          one_hz_tick,
  input  wire logic                          alarm1_match,
  input  wire logic                          alarm2_match,
  output logic                               hour_format_select,
  output logic                               mains_ref_edge,
  output logic [14:0]                        sync_divider_value,
  // Interrupt
  output logic                               irq
);

  // ----------------------------------------------------------------
  // Registers and nets
  // ----------------------------------------------------------------
  rcl_pkg::rcl_ctrl_t                 ctrl;
  rcl_pkg::rcl_bus_state_t            bus_q;
  logic [31:0]                        control_q;
  logic [rcl_pkg::EVT_COUNT-1:0]      status_q;
  logic [rcl_pkg::EVT_COUNT-1:0]      mask_q;
  logic [rcl_pkg::EVT_COUNT-1:0]      events;
  logic [rcl_pkg::EVT_COUNT-1:0]      gate;
  logic [15:0]                        reload_q;
  logic [14:0]                        sync_div_q;
  logic [rcl_pkg::TIME_W-1:0]         time_shadow_q;
  logic [rcl_pkg::DATE_W-1:0]         date_shadow_q;
  logic [rcl_pkg::TIME_W-1:0]         stamp_time_q;
  logic [31:0]                        rdata_q;
  logic [31:0]                        rdata_d;
  logic [31:0]                        wmask;
  logic                               cal_half_q;
  logic [3:0]                         div_cnt_q;
  logic [rcl_pkg::WK_CNT_W-1:0]       wk_cnt_q;
  logic [rcl_pkg::WK_CNT_W-1:0]       wk_reload;
  logic                               cal_tick;
  logic                               shadow_load;
  logic                               div_hit;
  logic                               wk_tick;
  logic                               wk_event;
  logic                               ref_rise;
  logic                               stamp_rise;
  logic                               stamp_fall;
  logic                               stamp_event;
  logic                               req;
  logic                               wr_fire;

  assign ctrl = rcl_pkg::rcl_ctrl_t'(control_q);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  rcl_edge_sync u_cal_sync (
    .clk    (clk),
    .reset  (reset),
    .pin_in (calendar_clock),
    .level  (),
    .rise   (cal_tick),
    .fall   ()
  );

  rcl_edge_sync u_ref_sync (
    .clk    (clk),
    .reset  (reset),
    .pin_in (mains_ref_input),
    .level  (),
    .rise   (ref_rise),
    .fall   ()
  );

  rcl_edge_sync u_stamp_sync (
    .clk    (clk),
    .reset  (reset),
    .pin_in (stamp_input),
    .level  (),
    .rise   (stamp_rise),
    .fall   (stamp_fall)
  );

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // One wait cycle per access: the first edge latches read data, the second
  // completes the transfer, so read data always come from flip-flops.
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & (bus_q != rcl_pkg::BUS_ACK);
  assign wr_fire         = avs_write & (bus_q == rcl_pkg::BUS_ACK);
  assign avs_readdata    = rdata_q;
  assign wmask           = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_ff @(posedge clk) begin
    if (reset) begin
      bus_q <= rcl_pkg::BUS_IDLE;
    end else begin
      unique case (bus_q)
        rcl_pkg::BUS_IDLE: begin
          if (req) begin
            bus_q <= rcl_pkg::BUS_ACK;
          end
        end
        rcl_pkg::BUS_ACK: begin
          bus_q <= rcl_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (avs_address)
      rcl_pkg::OFF_TIME: begin
        rdata_d[rcl_pkg::TIME_W-1:0] = ctrl.shadow_bypass ? live_time : time_shadow_q;
      end
      rcl_pkg::OFF_DATE: begin
        rdata_d[rcl_pkg::DATE_W-1:0] = ctrl.shadow_bypass ? live_date : date_shadow_q;
      end
      rcl_pkg::OFF_CONTROL:  rdata_d = control_q;
      rcl_pkg::OFF_STATUS:   rdata_d[rcl_pkg::EVT_COUNT-1:0] = status_q;
      rcl_pkg::OFF_MASK:     rdata_d[rcl_pkg::EVT_COUNT-1:0] = mask_q;
      rcl_pkg::OFF_RELOAD:   rdata_d[15:0] = reload_q;
      rcl_pkg::OFF_SYNC_DIV: rdata_d[14:0] = sync_div_q;
      rcl_pkg::OFF_STAMP:    rdata_d[rcl_pkg::TIME_W-1:0] = stamp_time_q;
      default:               rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && bus_q == rcl_pkg::BUS_IDLE) begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      control_q <= rcl_pkg::CTL_RESET;
    end else if (wr_fire && avs_address == rcl_pkg::OFF_CONTROL) begin
      control_q <= (control_q & ~(wmask & rcl_pkg::CTL_WRITABLE))
                 | (avs_writedata & wmask & rcl_pkg::CTL_WRITABLE);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mask_q <= rcl_pkg::EVT_RESET;
    end else if (wr_fire && avs_address == rcl_pkg::OFF_MASK && avs_byteenable[0]) begin
      mask_q <= avs_writedata[rcl_pkg::EVT_COUNT-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reload_q <= rcl_pkg::RELOAD_RESET;
    end else if (wr_fire && avs_address == rcl_pkg::OFF_RELOAD) begin
      reload_q <= (reload_q & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
    end
  end

  // The divider is only stored here; its value matters to reference detection
  // and is the programmer's duty to set before enabling it.
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_div_q <= rcl_pkg::SYNC_DIV_RESET;
    end else if (wr_fire && avs_address == rcl_pkg::OFF_SYNC_DIV) begin
      sync_div_q <= (sync_div_q & ~wmask[14:0]) | (avs_writedata[14:0] & wmask[14:0]);
    end
  end

  assign sync_divider_value = sync_div_q;
  assign hour_format_select = ctrl.hour_format_select;

  // ----------------------------------------------------------------
  // Shadow calendar
  // ----------------------------------------------------------------
  assign shadow_load = cal_tick & cal_half_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      cal_half_q    <= 1'b0;
      time_shadow_q <= '0;
      date_shadow_q <= '0;
    end else begin
      if (cal_tick) begin
        cal_half_q <= ~cal_half_q;
      end
      if (shadow_load) begin
        time_shadow_q <= live_time;
        date_shadow_q <= live_date;
      end
    end
  end

  // ----------------------------------------------------------------
  // Wakeup timer
  // ----------------------------------------------------------------
  always_comb begin
    unique case (ctrl.wakeup_clock_select[1:0])
      2'b00:   div_hit = (div_cnt_q == 4'hF);
      2'b01:   div_hit = (div_cnt_q[2:0] == 3'h7);
      2'b10:   div_hit = (div_cnt_q[1:0] == 2'h3);
      default: div_hit = div_cnt_q[0];
    endcase
  end

  assign wk_tick   = ctrl.wakeup_clock_select[2] ? one_hz_tick : (cal_tick & div_hit);
  assign wk_reload = {ctrl.wakeup_clock_select[2] & ctrl.wakeup_clock_select[1], reload_q};
  assign wk_event  = ctrl.wakeup_timer_on & wk_tick & (wk_cnt_q == '0);

  always_ff @(posedge clk) begin
    if (reset) begin
      div_cnt_q <= 4'h0;
    end else if (cal_tick) begin
      div_cnt_q <= div_cnt_q + 4'h1;
    end
  end

  // While stopped, the counter tracks the reload value so that a new start
  // always counts a full period.
  always_ff @(posedge clk) begin
    if (reset) begin
      wk_cnt_q <= '0;
    end else if (!ctrl.wakeup_timer_on) begin
      wk_cnt_q <= wk_reload;
    end else if (wk_tick) begin
      if (wk_cnt_q == '0) begin
        wk_cnt_q <= wk_reload;
      end else begin
        wk_cnt_q <= wk_cnt_q - 17'h0_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Timestamp and reference detection
  // ----------------------------------------------------------------
  // Edges are found before the select, so changing the edge with capture enabled raises no event.
  assign stamp_event = ctrl.stamp_capture_enable
                     & (ctrl.stamp_edge_select ? stamp_fall : stamp_rise);
  assign mains_ref_edge = ctrl.mains_ref_detect_enable & ref_rise;

  always_ff @(posedge clk) begin
    if (reset) begin
      stamp_time_q <= '0;
    end else if (stamp_event) begin
      stamp_time_q <= live_time;
    end
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    events                      = '0;
    events[rcl_pkg::EVT_WAKEUP] = wk_event;
    events[rcl_pkg::EVT_ALARM1] = ctrl.alarm1_on & alarm1_match;
    events[rcl_pkg::EVT_ALARM2] = ctrl.alarm2_on & alarm2_match;
    events[rcl_pkg::EVT_STAMP]  = stamp_event;
    events[rcl_pkg::EVT_REF]    = mains_ref_edge;
  end

  always_comb begin
    gate                      = '1;
    gate[rcl_pkg::EVT_WAKEUP] = ctrl.wakeup_irq_enable;
    gate[rcl_pkg::EVT_ALARM2] = ctrl.alarm2_irq_enable;
    gate[rcl_pkg::EVT_ALARM1] = ctrl.alarm1_irq_enable;
  end

  // A new event wins over a write-one clear in the same cycle.
  always_ff @(posedge clk) begin
    if (reset) begin
      status_q <= rcl_pkg::EVT_RESET;
    end else if (wr_fire && avs_address == rcl_pkg::OFF_STATUS && avs_byteenable[0]) begin
      status_q <= (status_q & ~avs_writedata[rcl_pkg::EVT_COUNT-1:0]) | events;
    end else begin
      status_q <= status_q | events;
    end
  end

  assign irq = |(status_q & mask_q & gate);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  wakeup_gate_a: assert property (
    @(posedge clk) disable iff (reset)
    (status_q[rcl_pkg::EVT_WAKEUP] && !ctrl.wakeup_irq_enable
     && status_q[4:1] == '0) |-> !irq)
    else $error("wakeup interrupt not gated");

  alarm2_gate_a: assert property (
    @(posedge clk) disable iff (reset)
    (status_q == 5'h04 && mask_q[rcl_pkg::EVT_ALARM2]) |->
      (irq == ctrl.alarm2_irq_enable))
    else $error("second alarm interrupt gating wrong");

  alarm1_gate_a: assert property (
    @(posedge clk) disable iff (reset)
    (status_q == 5'h02 && mask_q[rcl_pkg::EVT_ALARM1]) |->
      (irq == ctrl.alarm1_irq_enable))
    else $error("first alarm interrupt gating wrong");

  wakeup_stop_a: assert property (
    @(posedge clk) disable iff (reset)
    !ctrl.wakeup_timer_on |=> (wk_cnt_q == $past(wk_reload)))
    else $error("stopped wakeup counter not held at reload");

  alarm_enable_a: assert property (
    @(posedge clk) disable iff (reset)
    (ctrl.alarm1_on && alarm1_match) |=> status_q[rcl_pkg::EVT_ALARM1])
    else $error("first alarm match not flagged");

  hour_format_a: assert property (
    @(posedge clk) disable iff (reset)
    hour_format_select == control_q[rcl_pkg::CTL_HOUR_FMT])
    else $error("hour format output wrong");

  sequence shadow_refresh_s;
    shadow_load ##1 1'b1;
  endsequence

  shadow_copy_a: assert property (
    @(posedge clk) disable iff (reset)
    shadow_refresh_s |-> (time_shadow_q == $past(live_time)))
    else $error("shadow time not refreshed");

  bypass_read_a: assert property (
    @(posedge clk) disable iff (reset)
    (avs_read && bus_q == rcl_pkg::BUS_IDLE && avs_address == rcl_pkg::OFF_TIME
     && ctrl.shadow_bypass) |=> (avs_readdata[rcl_pkg::TIME_W-1:0] == $past(live_time)))
    else $error("bypass read not live");

  ref_detect_a: assert property (
    @(posedge clk) disable iff (reset)
    !ctrl.mains_ref_detect_enable |-> !mains_ref_edge)
    else $error("reference edge while detection off");

  stamp_edge_a: assert property (
    @(posedge clk) disable iff (reset)
    (ctrl.stamp_capture_enable && !ctrl.stamp_edge_select && stamp_rise)
      |=> status_q[rcl_pkg::EVT_STAMP] && stamp_time_q == $past(live_time))
    else $error("rising stamp edge not captured");

  div16_tick_a: assert property (
    @(posedge clk) disable iff (reset)
    (wk_tick && ctrl.wakeup_clock_select == rcl_pkg::WKSEL_DIV16) |-> div_cnt_q == 4'hF)
    else $error("divide by sixteen tick misplaced");

  spre_reload_a: assert property (
    @(posedge clk) disable iff (reset)
    (!ctrl.wakeup_timer_on && ctrl.wakeup_clock_select[2:1] == 2'b11)
      |=> wk_cnt_q == {1'b1, $past(reload_q)})
    else $error("extra 2^16 not added");

  bus_answer_a: assert property (
    @(posedge clk) disable iff (reset)
    (req && bus_q == rcl_pkg::BUS_IDLE) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait cycle");

endmodule

// *** tb/test_rtc_control_low_fields.sv ***
// Self-checking bench for the control register block and its events.
`timescale 1ns/1ps
module test_rtc_control_low_fields;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdat;
  logic        waitreq;
  logic        cal = 1'b0;
  logic        ref_in = 1'b0;
  logic        stamp = 1'b0;
  logic [2:0]  ev = 3'h0;
  logic [22:0] ltime = 23'h00_0000;
  logic [23:0] ldate = 24'h00_0000;
  logic        hfs;
  logic        ref_edge;
  logic [14:0] sdiv;
  logic        irq;
  logic [31:0] q;
  logic [31:0] v;
  logic [22:0] t0;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          cal_edges = 0;
  int          ref_cnt = 0;
  int          n;
  int          dv;

  rcl_control dut_u (
    .clk                (clk),
    .reset              (reset),
    .avs_address        (adr),
    .avs_read           (rd),
    .avs_write          (wr),
    .avs_writedata      (wd),
    .avs_byteenable     (4'hF),
    .avs_readdata       (rdat),
    .avs_waitrequest    (waitreq),
    .calendar_clock     (cal),
    .mains_ref_input    (ref_in),
    .stamp_input        (stamp),
    .live_time          (ltime),
    .live_date          (ldate),
    .one_hz_tick        (ev[2]),
    .alarm1_match       (ev[0]),
    .alarm2_match       (ev[1]),
    .hour_format_select (hfs),
    .mains_ref_edge     (ref_edge),
    .sync_divider_value (sdiv),
    .irq                (irq)
  );

  always #2.5 clk = ~clk;

  // The reference pulse lasts one cycle, so it is counted once per rising edge of the pin while detection is enabled.
  always @(posedge clk) begin
    cycles++;
    if (ref_edge === 1'b1) begin
      ref_cnt++;
    end
    if (cycles == 40000) begin
      bad_count++;
      test_done;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] bt(input int b);
    return 32'h0000_0001 << b;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The request is held until a rising edge samples waitrequest low; read
  // data are taken at that same edge, before anything is released.
  task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] d);
    @(posedge clk);
    adr <= ad;
    wr <= w;
    rd <= !w;
    wd <= d;
    @(posedge clk);
    while (waitreq !== 1'b0) begin
      @(posedge clk);
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [4:0] ad, input logic [31:0] exp);
    bus(1'b0, ad, 32'h0000_0000);
    check(q, exp);
  endtask

  // The interrupt follows a write at its completing edge, so it is looked
  // at half a cycle later, once it has settled.
  task automatic irq_chk(input logic [31:0] exp);
    @(negedge clk);
    check(32'(irq), exp);
  endtask

  task automatic ctick;
    @(posedge clk);
    cal <= 1'b1;
    repeat (4) @(posedge clk);
    cal <= 1'b0;
    repeat (4) @(posedge clk);
    cal_edges++;
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic pin_wait;
    repeat (6) @(posedge clk);
  endtask

  task automatic test_done;
    if (bad_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(83));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd_chk(rcl_pkg::OFF_CONTROL, rcl_pkg::CTL_RESET);
    rd_chk(rcl_pkg::OFF_STATUS, 32'h0000_0000);
    rd_chk(rcl_pkg::OFF_RELOAD, 32'h0000_FFFF);
    rd_chk(rcl_pkg::OFF_SYNC_DIV, 32'h0000_00FF);
    check(32'(sdiv), 32'h0000_00FF);
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      bus(1'b1, rcl_pkg::OFF_CONTROL, v);
      rd_chk(rcl_pkg::OFF_CONTROL, v & rcl_pkg::CTL_WRITABLE);
      check(32'(hfs), 32'(v[6]));
    end
    bus(1'b1, rcl_pkg::OFF_CONTROL, bt(rcl_pkg::CTL_BYPASS));
    t0 = 23'($urandom);
    ltime <= t0;
    v = $urandom;
    ldate <= v[23:0];
    rd_chk(rcl_pkg::OFF_TIME, 32'(t0));
    rd_chk(rcl_pkg::OFF_DATE, 32'(v[23:0]));
    bus(1'b1, rcl_pkg::OFF_CONTROL, 32'h0000_0000);
    ctick;
    ctick;
    t0 = ltime;
    ltime <= 23'($urandom);
    rd_chk(rcl_pkg::OFF_TIME, 32'(t0));
    ctick;
    rd_chk(rcl_pkg::OFF_TIME, 32'(t0));
    ctick;
    rd_chk(rcl_pkg::OFF_TIME, 32'(ltime));
    bus(1'b1, rcl_pkg::OFF_MASK, 32'h0000_001F);
    for (int i = 0; i < 2; i++) begin
      pulse(i);
      rd_chk(rcl_pkg::OFF_STATUS, 32'h0000_0000);
      bus(1'b1, rcl_pkg::OFF_CONTROL, bt(8 + i));
      pulse(i);
      rd_chk(rcl_pkg::OFF_STATUS, bt(i + 1));
      check(32'(irq), 32'h0000_0000);
      bus(1'b1, rcl_pkg::OFF_CONTROL, bt(8 + i) | bt(12 + i));
      irq_chk(32'h0000_0001);
      bus(1'b1, rcl_pkg::OFF_MASK, 32'h0000_0000);
      irq_chk(32'h0000_0000);
      bus(1'b1, rcl_pkg::OFF_MASK, 32'h0000_001F);
      bus(1'b1, rcl_pkg::OFF_STATUS, bt(i + 1));
      rd_chk(rcl_pkg::OFF_STATUS, 32'h0000_0000);
      bus(1'b1, rcl_pkg::OFF_CONTROL, 32'h0000_0000);
    end
    bus(1'b1, rcl_pkg::OFF_CONTROL, bt(rcl_pkg::CTL_STAMP_EN));
    stamp <= 1'b1;
    pin_wait;
    rd_chk(rcl_pkg::OFF_STATUS, 32'h0000_0008);
    rd_chk(rcl_pkg::OFF_STAMP, 32'(ltime));
    bus(1'b1, rcl_pkg::OFF_STATUS, 32'h0000_0008);
    stamp <= 1'b0;
    pin_wait;
    rd_chk(rcl_pkg::OFF_STATUS, 32'h0000_0000);
    bus(1'b1, rcl_pkg::OFF_CONTROL, bt(rcl_pkg::CTL_STAMP_EDGE));
    bus(1'b1, rcl_pkg::OFF_CONTROL, bt(3) | bt(rcl_pkg::CTL_STAMP_EN));
    stamp <= 1'b1;
    pin_wait;
    rd_chk(rcl_pkg::OFF_STATUS, 32'h0000_0000);
    stamp <= 1'b0;
    pin_wait;
    rd_chk(rcl_pkg::OFF_STATUS, 32'h0000_0008);
    bus(1'b1, rcl_pkg::OFF_STATUS, 32'h0000_0008);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, rcl_pkg::OFF_CONTROL, i ? bt(rcl_pkg::CTL_REF_DETECT) : 32'h0);
      ref_cnt = 0;
      ref_in <= 1'b1;
      pin_wait;
      ref_in <= 1'b0;
      pin_wait;
      check(32'(ref_cnt), 32'(i));
      rd_chk(rcl_pkg::OFF_STATUS, i ? 32'h0000_0010 : 32'h0);
    end
    bus(1'b1, rcl_pkg::OFF_STATUS, 32'h0000_0010);
    bus(1'b1, rcl_pkg::OFF_RELOAD, 32'h0000_0002);
    // The prescaler phase is unknown here, so only the bounds are fixed.
    for (int s = 0; s < 4; s++) begin
      dv = 16 >> s;
      bus(1'b1, rcl_pkg::OFF_CONTROL, bt(14) | bt(10) | 32'(s));
      n = 0;
      while (irq !== 1'b1 && n < 100) begin
        ctick;
        n++;
      end
      check(32'(n >= 2 * dv + 1 && n <= 3 * dv), 32'h0000_0001);
      bus(1'b1, rcl_pkg::OFF_CONTROL, 32'(s));
      bus(1'b1, rcl_pkg::OFF_STATUS, 32'h0000_0001);
    end
    repeat (10) ctick;
    rd_chk(rcl_pkg::OFF_STATUS, 32'h0000_0000);
    // A stopped counter follows the reload of the select in force, so the
    // select is changed first and the timer started by a second write.
    for (int s = 4; s < 8; s += 2) begin
      bus(1'b1, rcl_pkg::OFF_CONTROL, 32'(s));
      bus(1'b1, rcl_pkg::OFF_CONTROL, bt(14) | bt(10) | 32'(s));
      pulse(2);
      pulse(2);
      check(32'(irq), 32'h0000_0000);
      pulse(2);
      check(32'(irq), (s == 4) ? 32'h1 : 32'h0);
      bus(1'b1, rcl_pkg::OFF_CONTROL, bt(10) | 32'(s));
      irq_chk(32'h0000_0000);
      bus(1'b1, rcl_pkg::OFF_CONTROL, 32'(s));
      bus(1'b1, rcl_pkg::OFF_STATUS, 32'h0000_0001);
    end
    test_done;
  end
endmodule
